// ===== tpir_defines.svh
`ifndef TPIR_DEFINES_SVH
`define TPIR_DEFINES_SVH

// Register byte offsets (word aligned)
`define TPIR_ADDR_W           8
`define TPIR_OFF_MODE_CTRL    8'h00
`define TPIR_OFF_OUT_CTRL     8'h04
`define TPIR_OFF_ID_SAMPLE    8'h08
`define TPIR_OFF_IN_SAMPLE    8'h0C
`define TPIR_OFF_ACK_CTRL     8'h10
`define TPIR_OFF_REQ_SAMPLE   8'h14

// Field positions
`define TPIR_MODE_ON_BIT      0
`define TPIR_OUT_ATREADY_BIT  0
`define TPIR_OUT_AFVALID_BIT  1
`define TPIR_IN_ATVALID_BIT   0
`define TPIR_IN_AFREADY_BIT   1
`define TPIR_IN_ATBYTES_LSB   8
`define TPIR_IN_ATBYTES_MSB   9
`define TPIR_ID_MSB           6
`define TPIR_ACK_TRIG_BIT     0
`define TPIR_ACK_FLUSH_BIT    1
`define TPIR_REQ_TRIG_BIT     0
`define TPIR_REQ_FLUSH_BIT    1

// Widths and reset values
`define TPIR_ATID_W           7
`define TPIR_ATBYTES_W        2
`define TPIR_CTRL_W           2
`define TPIR_MODE_W           1
`define TPIR_CTRL_RST         2'h0
`define TPIR_MODE_RST         1'h0
`define TPIR_WAIT_RST         1'h1
`define TPIR_OUT_RST          1'h0
`define TPIR_DATA_ZERO        32'h0000_0000

`endif

// ===== tpir_pkg.sv
package tpir_pkg;

  `include "tpir_defines.svh"

  // ATB slave-side inputs from the upstream trace source
  typedef struct packed {
    logic [`TPIR_ATBYTES_W-1:0] atbytes;
    logic [`TPIR_ATID_W-1:0]    atid;
    logic                       afready;
    logic                       atvalid;
  } tpir_atb_in_s;

  // Handshake outputs as produced by the functional logic
  typedef struct packed {
    logic triginack;
    logic flushinack;
    logic afvalid;
    logic atready;
  } tpir_func_out_s;

  // Trigger and flush request inputs
  typedef struct packed {
    logic flushin;
    logic trigin;
  } tpir_req_in_s;

endpackage : tpir_pkg

// ===== tpir_ctrl_reg.sv
`timescale 1ns/1ps
`include "tpir_defines.svh"

// Software-written control field with synchronous reset
module tpir_ctrl_reg #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clock,
  input  wire logic         i_srst,
  input  wire logic         i_we,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_q <= RST;
    end else if (i_we) begin
      o_q <= i_d;
    end
  end

endmodule : tpir_ctrl_reg

// ===== tpir_in_sample.sv
`timescale 1ns/1ps

// Captures an input group every cycle so reads see a settled value
module tpir_in_sample #(
  parameter int W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_q <= '0;
    end else begin
      o_q <= i_d;
    end
  end

endmodule : tpir_in_sample

// ===== tpir_top.sv
// What this block does
// - In integration mode AFVALID follows out-control bit 1, ATREADY bit 0.
// - Identifier sample returns ATID in bits 6:0, upper bits zero.
// - Input sample register returns ATVALID, AFREADY and ATBYTES fields.
// - AFREADY field reads 1 when AFREADY is high, else 0.
// - ATVALID field reads 1 when ATVALID is high, else 0.
// - Starts in functional mode; integration mode exposes pins to registers.
// - Normal trace behaviour may be unavailable during integration mode.
// - Software sets flush/trigger acks and reads flush/trigger requests.
// - Other test registers exercise only the ATB slave interface.
// - Mode-control bit 0 enables integration mode; bits 31:1 reserved.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tpir_defines.svh"

module tpir_top
  import tpir_pkg::*;
(
  input  wire logic                     i_clock,
  input  wire logic                     i_srst,
  input  wire logic [`TPIR_ADDR_W-1:0]  i_address,
  input  wire logic                     i_read,
  input  wire logic                     i_write,
  input  wire logic [31:0]              i_writedata,
  input  wire logic [3:0]               i_byteenable,
  output logic      [31:0]              o_readdata,
  output logic                          o_waitrequest,
  input  wire tpir_atb_in_s             i_atb_in,
  input  wire tpir_req_in_s             i_req_in,
  input  wire tpir_func_out_s           i_func_out,
  output logic                          o_atready,
  output logic                          o_afvalid,
  output logic                          o_flushinack,
  output logic                          o_triginack,
  output logic                          o_integration_mode_on
);

  // Bus slave: one wait cycle, then a single-cycle answer
  logic        wait_r;
  logic        wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  wire req_w      = i_read | i_write;
  wire answer_w   = req_w & wait_r;
  wire accept_w   = req_w & ~wait_r;
  wire wr_acc_w   = accept_w & i_write & i_byteenable[0];

  wire sel_mode_w = (i_address == `TPIR_OFF_MODE_CTRL);
  wire sel_out_w  = (i_address == `TPIR_OFF_OUT_CTRL);
  wire sel_id_w   = (i_address == `TPIR_OFF_ID_SAMPLE);
  wire sel_in_w   = (i_address == `TPIR_OFF_IN_SAMPLE);
  wire sel_ack_w  = (i_address == `TPIR_OFF_ACK_CTRL);
  wire sel_req_w  = (i_address == `TPIR_OFF_REQ_SAMPLE);

  // Control registers
  logic [`TPIR_MODE_W-1:0] mode_q;
  logic [`TPIR_CTRL_W-1:0] out_ctrl_q;
  logic [`TPIR_CTRL_W-1:0] ack_ctrl_q;

  tpir_ctrl_reg #(
    .W   (`TPIR_MODE_W),
    .RST (`TPIR_MODE_RST)
  ) u_mode_reg (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_we    (wr_acc_w & sel_mode_w),
    .i_d     (i_writedata[`TPIR_MODE_ON_BIT]),
    .o_q     (mode_q)
  );

  tpir_ctrl_reg #(
    .W   (`TPIR_CTRL_W),
    .RST (`TPIR_CTRL_RST)
  ) u_out_ctrl_reg (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_we    (wr_acc_w & sel_out_w),
    .i_d     (i_writedata[`TPIR_CTRL_W-1:0]),
    .o_q     (out_ctrl_q)
  );

  tpir_ctrl_reg #(
    .W   (`TPIR_CTRL_W),
    .RST (`TPIR_CTRL_RST)
  ) u_ack_ctrl_reg (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_we    (wr_acc_w & sel_ack_w),
    .i_d     (i_writedata[`TPIR_CTRL_W-1:0]),
    .o_q     (ack_ctrl_q)
  );

  // Input capture; inputs are synchronous so one stage is enough
  tpir_atb_in_s atb_samp_q;
  tpir_req_in_s req_samp_q;

  tpir_in_sample #(
    .W ($bits(tpir_atb_in_s))
  ) u_atb_sample (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_d     (i_atb_in),
    .o_q     (atb_samp_q)
  );

  tpir_in_sample #(
    .W ($bits(tpir_req_in_s))
  ) u_req_sample (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_d     (i_req_in),
    .o_q     (req_samp_q)
  );

  // Read values; unmapped and write-only offsets read as zero
  wire integ_on_w = mode_q[`TPIR_MODE_ON_BIT];
  logic [31:0] rd_mode_w;
  logic [31:0] rd_id_w;
  logic [31:0] rd_in_w;
  logic [31:0] rd_req_w;
  logic [31:0] rd_mux_w;

  always_comb begin
    rd_mode_w = `TPIR_DATA_ZERO;
    rd_mode_w[`TPIR_MODE_ON_BIT] = integ_on_w;
    rd_id_w = `TPIR_DATA_ZERO;
    rd_id_w[`TPIR_ID_MSB:0] = atb_samp_q.atid;
    rd_in_w = `TPIR_DATA_ZERO;
    rd_in_w[`TPIR_IN_ATVALID_BIT] = atb_samp_q.atvalid;
    rd_in_w[`TPIR_IN_AFREADY_BIT] = atb_samp_q.afready;
    rd_in_w[`TPIR_IN_ATBYTES_MSB:`TPIR_IN_ATBYTES_LSB] =
      atb_samp_q.atbytes;
    rd_req_w = `TPIR_DATA_ZERO;
    rd_req_w[`TPIR_REQ_TRIG_BIT]  = req_samp_q.trigin;
    rd_req_w[`TPIR_REQ_FLUSH_BIT] = req_samp_q.flushin;
  end

  assign rd_mux_w = sel_mode_w ? rd_mode_w :
                    sel_id_w   ? rd_id_w   :
                    sel_in_w   ? rd_in_w   :
                    sel_req_w  ? rd_req_w  : `TPIR_DATA_ZERO;

  // Waitrequest idles high; it drops for exactly one cycle per request
  assign wait_nxt  = ~answer_w;
  assign rdata_nxt = (answer_w & i_read) ? rd_mux_w : `TPIR_DATA_ZERO;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wait_r  <= `TPIR_WAIT_RST;
      rdata_r <= `TPIR_DATA_ZERO;
    end else begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_waitrequest = wait_r;
  assign o_readdata    = rdata_r;

  // Output selection. Registered so every output is a flop, at the
  // cost of one cycle of latency on the functional path.
  logic atready_nxt;
  logic afvalid_nxt;
  logic flushack_nxt;
  logic trigack_nxt;
  logic atready_r;
  logic afvalid_r;
  logic flushack_r;
  logic trigack_r;

  // Functional path is simply overridden, not kept coherent
  assign atready_nxt  = integ_on_w ? out_ctrl_q[`TPIR_OUT_ATREADY_BIT]
                                   : i_func_out.atready;
  assign afvalid_nxt  = integ_on_w ? out_ctrl_q[`TPIR_OUT_AFVALID_BIT]
                                   : i_func_out.afvalid;
  assign flushack_nxt = integ_on_w ? ack_ctrl_q[`TPIR_ACK_FLUSH_BIT]
                                   : i_func_out.flushinack;
  assign trigack_nxt  = integ_on_w ? ack_ctrl_q[`TPIR_ACK_TRIG_BIT]
                                   : i_func_out.triginack;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      atready_r  <= `TPIR_OUT_RST;
      afvalid_r  <= `TPIR_OUT_RST;
      flushack_r <= `TPIR_OUT_RST;
      trigack_r  <= `TPIR_OUT_RST;
    end else begin
      atready_r  <= atready_nxt;
      afvalid_r  <= afvalid_nxt;
      flushack_r <= flushack_nxt;
      trigack_r  <= trigack_nxt;
    end
  end

  assign o_atready             = atready_r;
  assign o_afvalid             = afvalid_r;
  assign o_flushinack          = flushack_r;
  assign o_triginack           = trigack_r;
  assign o_integration_mode_on = integ_on_w;

  // Checks
  property p_atready_integ;
    @(posedge i_clock) disable iff (i_srst)
    integ_on_w |=> o_atready == $past(out_ctrl_q[`TPIR_OUT_ATREADY_BIT]);
  endproperty
  a_atready_integ: assert property (p_atready_integ)
    else $error("atready does not follow out-control bit 0");

  property p_afvalid_integ;
    @(posedge i_clock) disable iff (i_srst)
    integ_on_w |=> o_afvalid == $past(out_ctrl_q[`TPIR_OUT_AFVALID_BIT]);
  endproperty
  a_afvalid_integ: assert property (p_afvalid_integ)
    else $error("afvalid does not follow out-control bit 1");

  property p_id_read;
    @(posedge i_clock) disable iff (i_srst)
    (!o_waitrequest && $past(i_read) && $past(sel_id_w))
      |-> (o_readdata[`TPIR_ID_MSB:0] == $past(atb_samp_q.atid)) &&
          (o_readdata[31:`TPIR_ID_MSB+1] == '0);
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identifier sample read is wrong");

  property p_in_read;
    @(posedge i_clock) disable iff (i_srst)
    (!o_waitrequest && $past(i_read) && $past(sel_in_w))
      |-> o_readdata[`TPIR_IN_ATBYTES_MSB:`TPIR_IN_ATBYTES_LSB]
          == $past(atb_samp_q.atbytes);
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("atbytes field read is wrong");

  property p_afready_read;
    @(posedge i_clock) disable iff (i_srst)
    (!o_waitrequest && $past(i_read) && $past(sel_in_w))
      |-> o_readdata[`TPIR_IN_AFREADY_BIT] == $past(atb_samp_q.afready);
  endproperty
  a_afready_read: assert property (p_afready_read)
    else $error("afready field read is wrong");

  property p_atvalid_read;
    @(posedge i_clock) disable iff (i_srst)
    (!o_waitrequest && $past(i_read) && $past(sel_in_w))
      |-> o_readdata[`TPIR_IN_ATVALID_BIT] == $past(atb_samp_q.atvalid);
  endproperty
  a_atvalid_read: assert property (p_atvalid_read)
    else $error("atvalid field read is wrong");

  property p_reset_functional;
    @(posedge i_clock)
    $fell(i_srst) |-> !o_integration_mode_on;
  endproperty
  a_reset_functional: assert property (p_reset_functional)
    else $error("block did not leave reset in functional mode");

  property p_mode_write;
    @(posedge i_clock) disable iff (i_srst)
    (i_write && !o_waitrequest && i_byteenable[0] && sel_mode_w)
      |=> o_integration_mode_on == $past(i_writedata[`TPIR_MODE_ON_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("mode write did not take effect");

  property p_func_path;
    @(posedge i_clock) disable iff (i_srst)
    !integ_on_w |=> (o_atready == $past(i_func_out.atready)) &&
                    (o_afvalid == $past(i_func_out.afvalid));
  endproperty
  a_func_path: assert property (p_func_path)
    else $error("functional handshake not passed through");

  property p_ack_integ;
    @(posedge i_clock) disable iff (i_srst)
    integ_on_w |=>
      (o_flushinack == $past(ack_ctrl_q[`TPIR_ACK_FLUSH_BIT])) &&
      (o_triginack == $past(ack_ctrl_q[`TPIR_ACK_TRIG_BIT]));
  endproperty
  a_ack_integ: assert property (p_ack_integ)
    else $error("ack outputs do not follow ack control");

  property p_one_wait_answer;
    @(posedge i_clock) disable iff (i_srst)
    (req_w && o_waitrequest) |=> !o_waitrequest ##1 o_waitrequest;
  endproperty
  a_one_wait_answer: assert property (p_one_wait_answer)
    else $error("bus answer not a single cycle after one wait");

  property p_req_read;
    @(posedge i_clock) disable iff (i_srst)
    (!o_waitrequest && $past(i_read) && $past(sel_req_w))
      |-> (o_readdata[`TPIR_REQ_TRIG_BIT] == $past(req_samp_q.trigin)) &&
          (o_readdata[`TPIR_REQ_FLUSH_BIT] == $past(req_samp_q.flushin));
  endproperty
  a_req_read: assert property (p_req_read)
    else $error("request sample read is wrong");

  // Reserved bits must read zero so software can probe safely
  property p_mode_read;
    @(posedge i_clock) disable iff (i_srst)
    (!o_waitrequest && $past(i_read) && $past(sel_mode_w))
      |-> (o_readdata[`TPIR_MODE_ON_BIT] == $past(integ_on_w)) &&
          (o_readdata[31:`TPIR_MODE_ON_BIT+1] == '0);
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode-control read is wrong");

  property p_in_reserved;
    @(posedge i_clock) disable iff (i_srst)
    (!o_waitrequest && $past(i_read) && $past(sel_in_w))
      |-> (o_readdata[31:`TPIR_IN_ATBYTES_MSB+1] == '0) &&
          (o_readdata[`TPIR_IN_ATBYTES_LSB-1:`TPIR_IN_AFREADY_BIT+1] == '0);
  endproperty
  a_in_reserved: assert property (p_in_reserved)
    else $error("input sample reserved bits not zero");

  // Out and ack control registers are write-only: reading them must not leak state
  property p_wo_read;
    @(posedge i_clock) disable iff (i_srst)
    (!o_waitrequest && $past(i_read) &&
     ($past(sel_out_w) || $past(sel_ack_w)))
      |-> o_readdata == `TPIR_DATA_ZERO;
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only register did not read zero");

  property p_out_reset;
    @(posedge i_clock)
    $fell(i_srst) |-> !o_atready && !o_afvalid && !o_flushinack &&
                      !o_triginack;
  endproperty
  a_out_reset: assert property (p_out_reset)
    else $error("handshake outputs not low after reset");

  c_enter_integ: cover property (@(posedge i_clock) disable iff (i_srst)
    $rose(o_integration_mode_on));
  c_drive_both: cover property (@(posedge i_clock) disable iff (i_srst)
    integ_on_w && o_atready && o_afvalid);
  c_read_valid: cover property (@(posedge i_clock) disable iff (i_srst)
    !o_waitrequest && i_read && sel_in_w &&
    o_readdata[`TPIR_IN_ATVALID_BIT]);
  c_leave_integ: cover property (@(posedge i_clock) disable iff (i_srst)
    $fell(o_integration_mode_on));
  c_read_req: cover property (@(posedge i_clock) disable iff (i_srst)
    !o_waitrequest && i_read && sel_req_w && o_readdata[`TPIR_REQ_FLUSH_BIT]);

endmodule : tpir_top

// ===== tpir_src_model.sv
`timescale 1ns/1ps

// Upstream trace source: offers one beat per go pulse, answers flushes
module tpir_src_model
  import tpir_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_go,
  input  wire logic       i_slow,
  input  wire logic [6:0] i_id,
  input  wire logic [1:0] i_bytes,
  input  wire logic       i_atready,
  input  wire logic       i_afvalid,
  output tpir_atb_in_s    o_atb
);
  logic [2:0] fl_cnt_r;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_atb    <= '0;
      fl_cnt_r <= 3'h0;
    end else begin
      if (o_atb.atvalid && !i_atready) begin
        o_atb <= o_atb;
      end else if (i_go) begin
        o_atb.atvalid <= 1'b1;
        o_atb.atid    <= i_id;
        o_atb.atbytes <= i_bytes;
      end else begin
        // Idle lines keep moving so a stale value is never mistaken for data
        o_atb.atvalid <= 1'b0;
        o_atb.atid    <= ~o_atb.atid;
        o_atb.atbytes <= ~o_atb.atbytes;
      end
      fl_cnt_r <= !i_afvalid ? 3'h0 : fl_cnt_r + {2'h0, fl_cnt_r != 3'h7};
      // Slow source answers a flush late, then holds it while it is asked
      o_atb.afready <= i_afvalid && (!i_slow || fl_cnt_r >= 3'h3);
    end
  end
endmodule : tpir_src_model

// ===== tpir_top_tb.sv
`timescale 1ns/1ps

module tpir_top_tb
  import tpir_pkg::*;
;
  logic           i_clock, i_srst, rd, wr, go, slow, atready, afvalid;
  logic           flack, track, mode, wreq;
  logic [7:0]     addr;
  logic [31:0]    wdata, rdata, q;
  logic [3:0]     be;
  logic [6:0]     id;
  logic [1:0]     bytes;
  tpir_atb_in_s   atb;
  tpir_req_in_s   req;
  tpir_func_out_s fout;
  int             fails, n_tests;

  tpir_top tpir_top_inst (.i_clock(i_clock), .i_srst(i_srst),
    .i_address(addr), .i_read(rd), .i_write(wr), .i_writedata(wdata),
    .i_byteenable(be), .o_readdata(rdata), .o_waitrequest(wreq),
    .i_atb_in(atb), .i_req_in(req), .i_func_out(fout), .o_atready(atready),
    .o_afvalid(afvalid), .o_flushinack(flack), .o_triginack(track),
    .o_integration_mode_on(mode));

  tpir_src_model tpir_src_model_inst (.i_clock(i_clock), .i_srst(i_srst),
    .i_go(go), .i_slow(slow), .i_id(id), .i_bytes(bytes),
    .i_atready(atready), .i_afvalid(afvalid), .o_atb(atb));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task stop_test;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc

  // One request held until waitrequest is seen low at a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] b);
    int n;
    @(posedge i_clock);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    be    <= b;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : xfer

  task wr32(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
    cyc(3);
  endtask : wr32

  task rdchk(input logic [7:0] a, input logic [31:0] m,
             input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(q & m, e);
  endtask : rdchk

  task t_reset_func;
    chk({31'h0, mode}, 32'h0);
    rdchk(8'h00, 32'hFFFFFFFF, 32'h0);
    wr32(8'h04, 32'h3);
    fout <= 4'hF;
    cyc(3);
    chk({track, flack, afvalid, atready}, 4'hF);
    fout <= 4'h0;
    cyc(3);
    chk({track, flack, afvalid, atready}, 4'h0);
  endtask : t_reset_func

  task t_mode_out;
    xfer(1'b1, 8'h00, 32'hFFFFFFFF, 4'hE);
    rdchk(8'h00, 32'hFFFFFFFF, 32'h0);
    wr32(8'h00, 32'hFFFFFFFF);
    rdchk(8'h00, 32'hFFFFFFFF, 32'h1);
    chk({31'h0, mode}, 32'h1);
    for (int v = 0; v < 4; v++) begin
      fout <= ~v[3:0];
      wr32(8'h04, v);
      chk({afvalid, atready}, v[1:0]);
      rdchk(8'h04, 32'hFFFFFFFF, 32'h0);
    end
  endtask : t_mode_out

  task t_sample;
    for (int s = 0; s < 2; s++) begin
      slow  <= s[0];
      id    <= s ? 7'h7F : 7'h2A;
      bytes <= s ? 2'h3 : 2'h1;
      wr32(8'h04, 32'h2);
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(8);
      rdchk(8'h0C, 32'hFFFFFFFF, {22'h0, bytes, 8'h3});
      rdchk(8'h08, 32'hFFFFFFFF, {25'h0, id});
      wr32(8'h04, 32'h1);
      rdchk(8'h0C, 32'hFFFFFCFF, 32'h0);
    end
  endtask : t_sample

  task t_ack_req;
    for (int v = 0; v < 4; v++) begin
      wr32(8'h10, v);
      chk({flack, track}, v[1:0]);
      req <= v[1:0];
      cyc(3);
      rdchk(8'h14, 32'hFFFFFFFF, v);
    end
    rdchk(8'h18, 32'hFFFFFFFF, 32'h0);
  endtask : t_ack_req

  task t_exit;
    wr32(8'h00, 32'h0);
    fout <= 4'hA;
    cyc(3);
    chk({track, flack, afvalid, atready}, 4'hA);
    wr32(8'h00, 32'h1);
    i_srst <= 1'b1;
    cyc(2);
    i_srst <= 1'b0;
    cyc(1);
    chk({31'h0, mode}, 32'h0);
    rdchk(8'h00, 32'hFFFFFFFF, 32'h0);
  endtask : t_exit

  initial begin
    {i_srst, rd, wr, go, slow} = 5'h10;
    {addr, wdata, be, id, bytes} = '0;
    req = '0;
    fout = '0;
    fails = 0;
    n_tests = 0;
    cyc(3);
    i_srst <= 1'b0;
    cyc(1);
    t_reset_func();
    t_mode_out();
    t_sample();
    t_ack_req();
    t_exit();
    stop_test();
  end

  // Whole run needs well under 1000 cycles
  initial begin
    cyc(5000);
    fails++;
    stop_test();
  end
endmodule : tpir_top_tb
